// ===== rtl/usc_top.sv
// serial port status/control, transmit and receive paths, apb slave
// assumes a 40 MHz pclk, rx pin asynchronous, four-word fifos below
`timescale 1ns/100ps
`default_nettype none
`include "usc_params.svh"

module usc_top (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial pins
    input  wire logic        serial_rx_pin_i,
    output logic             serial_tx_pin_o,
    output logic             serial_tx_pin_oe,
    // one-cycle event strobes
    output logic             tx_irq,
    output logic             rx_irq
);
    import usc_pkg::*;

    function automatic logic usc_hit(input logic [11:0] a, input logic [11:0] off);
        return (a[11:2] == off[11:2]);
    endfunction

    usc_fifo_if #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) txf ();
    usc_fifo_if #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) rxf ();

    usc_st_t     s;
    usc_st_t     n;
    logic        setup;
    logic        acc;
    logic        hit_stat;
    logic        hit_txd;
    logic        hit_rxd;
    logic        hit_mode;
    logic        wr_go;
    logic        tx_tick;
    logic        rx_tick;
    logic        tx_pop;
    logic        rx_push;
    logic        ovr;
    logic        tx_line;
    logic [15:0] stat;
    logic [31:0] rv;

    // transmit and receive buffers
    usc_fifo #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) u_txf (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (txf)
    );
    usc_fifo #(.W(`USC_DATA_W), .D(`USC_FIFO_DEPTH)) u_rxf (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (rxf)
    );

    // apb decode
    assign setup = psel & ~penable;
    assign acc = psel & penable;
    assign hit_stat = usc_hit(paddr, `USC_OFF_STAT);
    assign hit_txd = usc_hit(paddr, `USC_OFF_TXD);
    assign hit_rxd = usc_hit(paddr, `USC_OFF_RXD);
    assign hit_mode = usc_hit(paddr, `USC_OFF_MODE);
    assign pslverr = acc & ~(hit_stat | hit_txd | hit_rxd | hit_mode);

    // a full tx buffer stalls the bus instead of dropping data
    assign txf.push_valid = acc & pwrite & hit_txd;
    assign txf.push_data = pwdata[7:0];
    assign pready = ~txf.push_valid | txf.push_ready;
    assign wr_go = acc & pwrite & pready & ~pslverr;
    assign txf.flush = ~s.txen;

    // shifter takes a char only when idle and no break pending
    assign tx_tick = (s.tx_div == 8'h00);
    assign txf.pop_ready = (s.tx_st == USC_TX_IDLE) & s.txen & ~s.brk;
    assign tx_pop = txf.pop_valid & txf.pop_ready;

    // rx buffer fills at stop bit, drains on data read
    assign rx_tick = (s.rx_div == 8'h00);
    assign rx_push = (s.rx_st == USC_RX_STOP) & rx_tick;
    assign rxf.push_valid = rx_push;
    assign rxf.push_data = s.rx_sh;
    assign rxf.flush = 1'h0;
    assign rxf.pop_ready = acc & ~pwrite & hit_rxd & s.rd_ok;
    assign ovr = rx_push & ~rxf.push_ready;

    // status word assembly
    always_comb
    begin
        stat = '0;
        stat[`USC_B_TXIS1] = s.txis[1];
        stat[`USC_B_INV] = s.inv;
        stat[`USC_B_TXIS0] = s.txis[0];
        stat[`USC_B_BRK] = s.brk;
        stat[`USC_B_TXEN] = s.txen;
        stat[`USC_B_TXBF] = ~txf.push_ready;
        stat[`USC_B_TX_SHIFTER_EMPTY_FLAG] = (s.tx_st == USC_TX_IDLE) & ~txf.pop_valid;
        stat[`USC_B_RXIS +: 2] = s.rxis;
        stat[`USC_B_IDLE] = (s.rx_st == USC_RX_IDLE);
        stat[`USC_B_RX_PARITY_ERROR_FLAG] = 1'h0; // no parity framing in this port
        stat[`USC_B_RX_FRAMING_ERROR_FLAG] = s.rx_framing_error_flag;
        stat[`USC_B_RX_OVERRUN_FLAG] = s.rx_overrun_flag;
        stat[`USC_B_RXDA] = rxf.pop_valid;
        rv = 32'h0;
        if (hit_stat)
            rv = {16'h0, stat};
        else if (hit_rxd)
            rv = {24'h0, rxf.pop_data};
        else if (hit_mode)
            rv = {31'h0, s.ir};
    end

    // next state of the whole block
    always_comb
    begin
        n = s;
        n.tx_irq = 1'h0;
        n.rx_irq = 1'h0;

        // read data is captured in setup so prdata is registered
        if (setup)
        begin
            n.rdata = rv;
            n.rd_ok = rxf.pop_valid;
        end

        // transmit shifter
        if (s.tx_st == USC_TX_SHIFT)
        begin
            n.tx_div = tx_tick ? (`USC_BAUD_DIV - 8'h01) : (s.tx_div - 8'h01);
            if (tx_tick)
            begin
                n.tx_sh = {1'h1, s.tx_sh[13:1]};
                n.tx_cnt = s.tx_cnt - 4'h1;
                if (s.tx_cnt == 4'h1)
                begin
                    n.tx_st = USC_TX_IDLE;
                    n.brk_on = 1'h0;
                    if (s.brk_on)
                        n.brk = 1'h0;
                    if (s.txis == `USC_TXI_DONE && !txf.pop_valid && !txf.push_valid)
                        n.tx_irq = 1'h1;
                end
            end
        end
        else if (s.txen && s.brk)
        begin
            n.tx_st = USC_TX_SHIFT;
            n.brk_on = 1'h1;
            n.tx_sh = `USC_BRK_FRAME;
            n.tx_cnt = `USC_BRK_BITS;
            n.tx_div = `USC_BAUD_DIV - 8'h01;
        end
        else if (tx_pop)
        begin
            n.tx_st = USC_TX_SHIFT;
            n.tx_sh = {5'h1f, txf.pop_data, 1'h0};
            n.tx_cnt = `USC_CHR_BITS;
            n.tx_div = `USC_BAUD_DIV - 8'h01;
            if (s.txis == `USC_TXI_CHAR)
                n.tx_irq = 1'h1;
            if (s.txis == `USC_TXI_EMPTY && txf.count == 3'h1 && !txf.push_valid)
                n.tx_irq = 1'h1;
        end

        // disabling aborts whatever is on the line
        if (!s.txen)
        begin
            n.tx_st = USC_TX_IDLE;
            n.brk_on = 1'h0;
        end

        // receive synchroniser, second stage only is read
        n.rx_s1 = serial_rx_pin_i;
        n.rx_s2 = s.rx_s1;
        if (s.rx_st != USC_RX_IDLE)
            n.rx_div = rx_tick ? (`USC_BAUD_DIV - 8'h01) : (s.rx_div - 8'h01);
        case (s.rx_st)
            USC_RX_IDLE:
            begin
                if (!s.rx_s2)
                begin
                    n.rx_st = USC_RX_START;
                    n.rx_div = `USC_HALF_DIV - 8'h01;
                end
            end
            USC_RX_START:
            begin
                // mid-bit recheck filters short glitches
                if (rx_tick)
                begin
                    n.rx_st = s.rx_s2 ? USC_RX_IDLE : USC_RX_DATA;
                    n.rx_cnt = `USC_DATA_BITS;
                end
            end
            USC_RX_DATA:
            begin
                if (rx_tick)
                begin
                    n.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
                    n.rx_cnt = s.rx_cnt - 4'h1;
                    if (s.rx_cnt == 4'h1)
                        n.rx_st = USC_RX_STOP;
                end
            end
            USC_RX_STOP:
            begin
                if (rx_tick)
                begin
                    n.rx_st = USC_RX_IDLE;
                    n.rx_framing_error_flag = ~s.rx_s2;
                    if (rxf.push_ready)
                    begin
                        if (!s.rxis[1])
                            n.rx_irq = 1'h1;
                        if (s.rxis == `USC_RXI_3Q && rxf.count == `USC_LVL_3Q && !rxf.pop_ready)
                            n.rx_irq = 1'h1;
                        if (s.rxis == `USC_RXI_FULL && rxf.count == `USC_LVL_FULL && !rxf.pop_ready)
                            n.rx_irq = 1'h1;
                    end
                end
            end
            default:
                n.rx_st = USC_RX_IDLE;
        endcase

        // software writes; mode 11 is left to software to avoid
        if (wr_go && hit_stat)
        begin
            n.txis = {pwdata[`USC_B_TXIS1], pwdata[`USC_B_TXIS0]};
            n.inv = pwdata[`USC_B_INV];
            n.txen = pwdata[`USC_B_TXEN];
            n.rxis = pwdata[`USC_B_RXIS +: 2];
            n.rx_overrun_flag = s.rx_overrun_flag & pwdata[`USC_B_RX_OVERRUN_FLAG];
            if (pwdata[`USC_B_BRK])
                n.brk = 1'h1;
        end
        if (wr_go && hit_mode)
            n.ir = pwdata[`USC_B_INFRARED_ENCODER_ON];

        // overrun set beats a clear in the same cycle
        if (ovr)
            n.rx_overrun_flag = 1'h1;

        // pin level: data line with idle polarity per encoder mode
        tx_line = (n.tx_st == USC_TX_SHIFT) ? n.tx_sh[0] : 1'h1;
        n.tx_pin = tx_line ^ n.inv ^ n.ir;
    end

    // state register, idle line levels at reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.tx_pin <= 1'h1;
            s.rx_s1 <= 1'h1;
            s.rx_s2 <= 1'h1;
        end
        else
            s <= n;
    end

    // outputs straight from the state
    assign prdata = s.rdata;
    assign serial_tx_pin_o = s.tx_pin;
    assign serial_tx_pin_oe = s.txen;
    assign tx_irq = s.tx_irq;
    assign rx_irq = s.rx_irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_char_irq;
        tx_pop && s.txis == `USC_TXI_CHAR |=> tx_irq;
    endproperty
    a_char_irq: assert property (p_char_irq) else $error("tx char event missing");

    property p_empty_irq;
        tx_pop && s.txis == `USC_TXI_EMPTY |=> (tx_irq == !txf.pop_valid);
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("tx empty event wrong");

    property p_done_irq;
        tx_irq && s.txis == `USC_TXI_DONE |-> s.tx_st == USC_TX_IDLE && txf.count == 3'h0;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("tx done event early");

    property p_brk_low;
        $rose(s.brk_on) |-> (s.tx_sh[0] == 1'h0 && s.tx_st == USC_TX_SHIFT)[*8];
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");

    property p_brk_clr;
        $fell(s.brk_on) && $past(s.txen) && !$past(wr_go) |-> !s.brk;
    endproperty
    a_brk_clr: assert property (p_brk_clr) else $error("break bit kept");

    property p_abort;
        $fell(s.txen) |=> txf.count == 3'h0 && s.tx_st == USC_TX_IDLE && !serial_tx_pin_oe;
    endproperty
    a_abort: assert property (p_abort) else $error("disable did not abort");

    property p_full_rd;
        setup && hit_stat |=> prdata[`USC_B_TXBF] == ($past(txf.count) == 3'h4);
    endproperty
    a_full_rd: assert property (p_full_rd) else $error("full flag wrong");

    property p_rx_full;
        rx_push && rxf.push_ready && s.rxis == `USC_RXI_FULL
            |=> rx_irq == ($past(rxf.count) == `USC_LVL_FULL && !$past(rxf.pop_ready));
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("rx full event wrong");

    property p_rx_overrun_flag_hold;
        s.rx_overrun_flag && !(wr_go && hit_stat) |=> s.rx_overrun_flag;
    endproperty
    a_rx_overrun_flag_hold: assert property (p_rx_overrun_flag_hold) else $error("overrun lost");
endmodule
`default_nettype wire

// ===== rtl/usc_params.svh
// constants of the serial status/control block
// assumes byte addresses on a 32-bit apb, 40 MHz pclk
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// register byte offsets
`define USC_OFF_STAT 12'h000
`define USC_OFF_TXD 12'h004
`define USC_OFF_RXD 12'h008
`define USC_OFF_MODE 12'h00c

// serial_status_control field positions
`define USC_B_TXIS1 15
`define USC_B_INV 14
`define USC_B_TXIS0 13
`define USC_B_BRK 11
`define USC_B_TXEN 10
`define USC_B_TXBF 9
`define USC_B_TX_SHIFTER_EMPTY_FLAG 8
`define USC_B_RXIS 6
`define USC_B_IDLE 4
`define USC_B_RX_PARITY_ERROR_FLAG 3
`define USC_B_RX_FRAMING_ERROR_FLAG 2
`define USC_B_RX_OVERRUN_FLAG 1
`define USC_B_RXDA 0
`define USC_B_INFRARED_ENCODER_ON 0
`define USC_STAT_RESET 16'h0110

// interrupt mode codes
`define USC_TXI_CHAR 2'h0
`define USC_TXI_DONE 2'h1
`define USC_TXI_EMPTY 2'h2
`define USC_RXI_3Q 2'h2
`define USC_RXI_FULL 2'h3
`define USC_LVL_3Q 3'h2
`define USC_LVL_FULL 3'h3

// bit timing and framing
`define USC_BAUD_DIV 8'h10
`define USC_HALF_DIV 8'h08
`define USC_CHR_BITS 4'ha
`define USC_BRK_BITS 4'he
`define USC_DATA_BITS 4'h8
`define USC_BRK_FRAME 14'h2000
`define USC_DATA_W 8
`define USC_FIFO_DEPTH 4

`endif

// ===== rtl/usc_pkg.sv
// types of the serial status/control block
// assumes usc_params.svh is on the include path
package usc_pkg;

    typedef enum logic {USC_TX_IDLE, USC_TX_SHIFT} usc_tx_st_t;
    typedef enum logic [1:0] {USC_RX_IDLE, USC_RX_START, USC_RX_DATA, USC_RX_STOP} usc_rx_st_t;

    // whole state of the top module
    typedef struct packed {
        logic [1:0]  txis;
        logic        inv;
        logic        brk;
        logic        txen;
        logic [1:0]  rxis;
        logic        ir;
        logic        rx_overrun_flag;
        logic        rx_framing_error_flag;
        usc_tx_st_t  tx_st;
        logic        brk_on;
        logic [13:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic [7:0]  tx_div;
        logic        tx_pin;
        logic        tx_irq;
        logic        rx_s1;
        logic        rx_s2;
        usc_rx_st_t  rx_st;
        logic [7:0]  rx_sh;
        logic [3:0]  rx_cnt;
        logic [7:0]  rx_div;
        logic        rx_irq;
        logic [31:0] rdata;
        logic        rd_ok;
    } usc_st_t;

endpackage

// ===== rtl/usc_fifo_if.sv
// fifo carrier between the top module and its buffers
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface usc_fifo_if #(
    parameter int W = 8,
    parameter int D = 4
) ();
    logic                       push_valid;
    logic                       push_ready;
    logic [W-1:0]               push_data;
    logic                       pop_valid;
    logic                       pop_ready;
    logic [W-1:0]               pop_data;
    logic [$clog2(D+1)-1:0]     count;
    logic                       flush;

    modport store (input push_valid, push_data, pop_ready, flush,
                   output push_ready, pop_valid, pop_data, count);
    modport user (output push_valid, push_data, pop_ready, flush,
                  input push_ready, pop_valid, pop_data, count);
endinterface
`default_nettype wire

// ===== rtl/usc_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes the user drives flush for a synchronous empty
`timescale 1ns/100ps
`default_nettype none
module usc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // both ports
    usc_fifo_if.store  f
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D+1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       rd;
        logic [AW-1:0]       wr;
        logic [CW-1:0]       cnt;
    } usc_fifo_st_t;

    usc_fifo_st_t s;
    usc_fifo_st_t n;
    logic         do_push;
    logic         do_pop;

    // honest full and empty from the count
    assign f.push_ready = (s.cnt != CW'(D));
    assign f.pop_valid = (s.cnt != '0);
    assign f.pop_data = s.mem[s.rd];
    assign f.count = s.cnt;
    assign do_push = f.push_valid & f.push_ready;
    assign do_pop = f.pop_valid & f.pop_ready;

    // pointers wrap at depth, flush wins over both sides
    always_comb
    begin
        n = s;
        if (f.flush)
        begin
            n.rd = '0;
            n.wr = '0;
            n.cnt = '0;
        end
        else
        begin
            if (do_push)
            begin
                n.mem[s.wr] = f.push_data;
                n.wr = (s.wr == AW'(D-1)) ? '0 : s.wr + AW'(1);
            end
            if (do_pop)
                n.rd = (s.rd == AW'(D-1)) ? '0 : s.rd + AW'(1);
            n.cnt = s.cnt + CW'(do_push) - CW'(do_pop);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= n;
    end
endmodule
`default_nettype wire

// ===== dv/usc_peer.sv
// remote serial peer: 8N1 receiver and transmitter, 16 pclk a bit
// assumes tx line not inverted while frames are exchanged
`timescale 1ns/100ps
`default_nettype none
module usc_peer (
    // clock
    input  wire logic pclk,
    // serial lines
    input  wire logic tx_o,
    input  wire logic tx_oe,
    output logic      rx_o
);
    int         ngot = 0;
    logic [7:0] gbyte;
    logic [7:0] b;
    // a released line rests at its pull-up level
    wire        txl = tx_oe ? tx_o : 1'b1;

    initial rx_o = 1'b1;

    // receive: wait for idle, find start, sample mid-bit, lsb first
    always
    begin
        @(negedge pclk iff txl);
        @(negedge pclk iff !txl);
        repeat (8) @(negedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(negedge pclk);
            b[i] = txl;
        end
        repeat (16) @(negedge pclk);
        gbyte = b;
        ngot++;
    end

    // one frame: start, data lsb first, stop; ends with line idle
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_o <= f[i];
            repeat (16) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_usc_top.sv
// self-checking bench for the serial status/control block
// assumes usc_top, usc_peer and the constants header
`timescale 1ns/100ps
`default_nettype none
`include "usc_params.svh"
module tb_usc_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    wire         rx_line;
    logic        tx_pin;
    logic        tx_oe;
    logic        tx_irq;
    logic        rx_irq;
    int          errors = 0;
    int          check_count = 0;
    int          ntx = 0;
    int          nrx = 0;
    int          run = 0;
    int          maxrun = 0;
    int          waits = 0;

    usc_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_rx_pin_i(rx_line),
        .serial_tx_pin_o(tx_pin), .serial_tx_pin_oe(tx_oe),
        .tx_irq(tx_irq), .rx_irq(rx_irq)
    );
    usc_peer peer_u (.pclk(pclk), .tx_o(tx_pin), .tx_oe(tx_oe), .rx_o(rx_line));

    always #12.5 pclk = ~pclk;

    // strobes and low runs sampled mid-cycle, clear of edge races
    always @(negedge pclk)
    begin
        if (tx_irq === 1'b1) ntx++;
        if (rx_irq === 1'b1) nrx++;
        if (tx_oe === 1'b1 && tx_pin === 1'b0) run++;
        else run = 0;
        if (run > maxrun) maxrun = run;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one apb transfer; request held until pready is seen high at a rising edge
    // an idle edge first, so back-to-back calls never drive psel twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 2000);
        if (n >= 2000) errors++;
        waits = n;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // poll status until shifter empty and no break pending
    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `USC_OFF_STAT, 32'h0);
            n++;
        end
        while ((rd[`USC_B_TX_SHIFTER_EMPTY_FLAG] !== 1'b1 || rd[`USC_B_BRK] !== 1'b0) && n < 600);
        if (n >= 600) errors++;
    endtask

    task automatic t_reset();
        apb(1'b0, `USC_OFF_STAT, 32'h0);
        chk(rd, {16'h0, `USC_STAT_RESET});
        apb(1'b1, `USC_OFF_STAT, 32'h031f);
        apb(1'b0, `USC_OFF_STAT, 32'h0);
        chk(rd, {16'h0, `USC_STAT_RESET});
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task automatic t_tx();
        logic [31:0] md [3] = '{32'h0400, 32'h8400, 32'h2400};
        int          ex [3] = '{3, 2, 1};
        int          g;
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, `USC_OFF_STAT, md[m]);
            ntx = 0;
            g = peer_u.ngot;
            for (int k = 0; k < 3; k++) apb(1'b1, `USC_OFF_TXD, 32'(8'h41 + k + m));
            apb(1'b0, `USC_OFF_STAT, 32'h0);
            chk(32'(rd[`USC_B_TX_SHIFTER_EMPTY_FLAG]), 32'h0);
            wait_done();
            repeat (20) @(posedge pclk);
            chk(32'(ntx), 32'(ex[m]));
            chk(32'(peer_u.ngot - g), 32'h3);
            chk(32'(peer_u.gbyte), 32'(8'h43 + m));
        end
    endtask

    task automatic t_full();
        apb(1'b1, `USC_OFF_STAT, 32'h0400);
        for (int k = 0; k < 4; k++) apb(1'b1, `USC_OFF_TXD, 32'(8'h30 + k));
        apb(1'b0, `USC_OFF_STAT, 32'h0);
        chk(32'(rd[`USC_B_TXBF]), 32'h0);
        apb(1'b1, `USC_OFF_TXD, 32'h34);
        apb(1'b0, `USC_OFF_STAT, 32'h0);
        chk(32'(rd[`USC_B_TXBF]), 32'h1);
        apb(1'b1, `USC_OFF_TXD, 32'h35);
        chk(32'(waits > 1), 32'h1);
        apb(1'b1, `USC_OFF_STAT, 32'h0);
        apb(1'b0, `USC_OFF_STAT, 32'h0);
        chk(32'(rd[15:8]), 32'h01);
        chk(32'(tx_oe), 32'h0);
        repeat (200) @(posedge pclk);
    endtask

    task automatic t_break();
        apb(1'b1, `USC_OFF_STAT, 32'h0400);
        maxrun = 0;
        apb(1'b1, `USC_OFF_STAT, 32'h0c00);
        wait_done();
        chk(32'(maxrun), 32'd208);
        chk(32'(rd[`USC_B_BRK]), 32'h0);
    endtask

    // idle level over all four polarity and encoder settings
    task automatic t_pol();
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, `USC_OFF_MODE, 32'(k[1]));
            apb(1'b1, `USC_OFF_STAT, k[0] ? 32'h4400 : 32'h0400);
            repeat (2) @(posedge pclk);
            chk(32'(tx_pin), 32'(!(k[0] ^ k[1])));
        end
        apb(1'b1, `USC_OFF_MODE, 32'h0);
    endtask

    task automatic t_rx();
        int ex [4] = '{4, 4, 1, 1};
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, `USC_OFF_STAT, 32'(m) << 6);
            nrx = 0;
            for (int k = 0; k < 4; k++) peer_u.send(8'(8'h60 + k));
            repeat (30) @(posedge pclk);
            chk(32'(nrx), 32'(ex[m]));
            if (m == 3)
            begin
                peer_u.send(8'h77);
                repeat (30) @(posedge pclk);
                apb(1'b0, `USC_OFF_STAT, 32'h0);
                chk(32'(rd[1:0]), 32'h3);
                chk(32'(nrx), 32'h1);
                apb(1'b1, `USC_OFF_STAT, 32'h00c0);
                apb(1'b0, `USC_OFF_STAT, 32'h0);
                chk(32'(rd[`USC_B_RX_OVERRUN_FLAG]), 32'h0);
            end
            for (int k = 0; k < 4; k++)
            begin
                apb(1'b0, `USC_OFF_RXD, 32'h0);
                chk(rd, 32'(8'h60 + k));
            end
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence: reset for ten cycles, then each scenario
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tx();
        t_full();
        t_break();
        t_pol();
        t_rx();
        wrap_up();
    end

    // watchdog, several times the expected run length
    initial
    begin
        #1000000;
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
